// ---- rtl/sdcr_pkg.sv ----
// Package for the synthesizer divider configuration register bank.
// Assumes a 32-bit APB slave; every configuration register is loaded through one word address and picked by its select code.
package sdcr_pkg;

   // Register select codes held in the low four bits of a word
   localparam logic [3:0] SEL_INT_PRESC  = 4'h0;
   localparam logic [3:0] SEL_MAIN_FRAC  = 4'h1;
   localparam logic [3:0] SEL_AUX_DEN    = 4'h2;
   localparam logic [3:0] SEL_AUX_NUM    = 4'h3;
   localparam logic [3:0] SEL_R4         = 4'h4;
   localparam logic [3:0] SEL_R5         = 4'h5;
   localparam logic [3:0] SEL_RF_OUT     = 4'h6;
   localparam logic [3:0] SEL_LOCK_DET   = 4'h7;
   localparam logic [3:0] SEL_DITHER_PH  = 4'h8;
   localparam int         NUM_REGS       = 9;

   // APB byte addresses
   localparam logic [7:0] ADDR_CFG_WORD  = 8'h00;   // Write: load a configuration word
   localparam logic [7:0] ADDR_LAST_WORD = 8'h04;   // Read: last loaded word
   localparam logic [7:0] ADDR_STATUS    = 8'h08;   // Read: pending shadow state
   localparam logic [7:0] ADDR_INT_VAL   = 8'h0C;   // Read: active whole divide value
   localparam logic [7:0] ADDR_MAIN_NUM  = 8'h10;   // Read: active main numerator
   localparam logic [7:0] ADDR_AUX_VAL   = 8'h14;   // Read: active aux den/num
   localparam logic [7:0] ADDR_RF_DIV    = 8'h18;   // Read: active output divider select

   // Field positions
   localparam int INT_LSB        = 4;
   localparam int INT_MSB        = 19;
   localparam int PRESC_BIT      = 20;
   localparam int MAIN_NUM_LSB   = 4;
   localparam int MAIN_NUM_MSB   = 27;
   localparam int AUX_LSB        = 4;
   localparam int AUX_MSB        = 17;
   localparam int DBUF_EN_BIT    = 14;
   localparam int RF_DIV_LSB     = 21;
   localparam int RF_DIV_MSB     = 23;

   // Reset values
   localparam logic [31:0] WORD_RESET = 32'h0000_0000;

   // Active divider settings presented to the loop
   typedef struct packed
   {
      logic        prescaler_select;        // 0: 4/5, 1: 8/9
      logic [15:0] whole_value;
      logic [23:0] main_fraction_numerator;
      logic [13:0] aux_denominator;
      logic [13:0] aux_fraction_numerator;
      logic [2:0]  rf_divider_select;
   } sdcr_div_t;

endpackage : sdcr_pkg

// ---- rtl/sdcr_shadow.sv ----
// Two-stage shadow holder for one buffered field.
// Assumes load and apply strobes are one-cycle pulses in the same clock domain.
`timescale 1ns/1ns
module sdcr_shadow #(
   parameter int W = 32
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         load_i,     // New value written
   input  wire logic         buffer_i,   // Hold in shadow until apply
   input  wire logic         apply_i,    // Register 0 write
   input  wire logic [W-1:0] data_i,
   output logic      [W-1:0] active_o,
   output logic              pending_o
);

   logic [W-1:0] shadow_q;
   logic [W-1:0] active_q;
   logic         pending_q;
   logic [W-1:0] shadow_d;
   logic [W-1:0] active_d;
   logic         pending_d;

   // Shadow follows every load
   assign shadow_d  = load_i ? data_i : shadow_q;
   // Apply moves the shadow in; a same-cycle load goes straight through
   assign active_d  = (load_i && !buffer_i) ? data_i :
                      apply_i               ? shadow_d : active_q;
   // Pending set wins over the apply that would clear it only if loaded later
   assign pending_d = (load_i && buffer_i && !apply_i) ? 1'b1 :
                      (apply_i || load_i)              ? 1'b0 : pending_q;

   // State update
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         shadow_q  <= '0;
         active_q  <= '0;
         pending_q <= 1'b0;
      end
      else
      begin
         shadow_q  <= shadow_d;
         active_q  <= active_d;
         pending_q <= pending_d;
      end
   end

   assign active_o  = active_q;
   assign pending_o = pending_q;

endmodule : sdcr_shadow

// ---- rtl/sdcr_regs.sv ----
// Configuration register bank of a fractional-N synthesizer, loaded over APB.
// Assumes a host writing full 32-bit words; one APB write to the load address is one completed load.
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
module sdcr_regs (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // APB slave
   input  wire logic              psel_i,
   input  wire logic              penable_i,
   input  wire logic              pwrite_i,
   input  wire logic [7:0]        paddr_i,
   input  wire logic [31:0]       pwdata_i,
   output logic                   pready_o,
   output logic                   pslverr_o,
   output logic      [31:0]       prdata_o,
   // Active divider settings
   output sdcr_pkg::sdcr_div_t    div_o,
   // Raw words of the other registers
   output logic      [31:0]       r4_word_o,
   output logic      [31:0]       r5_word_o,
   output logic      [31:0]       rf_out_word_o,
   output logic      [31:0]       lock_det_word_o,
   output logic      [31:0]       dither_ph_word_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode

   typedef enum logic [1:0] {SDCR_IDLE, SDCR_ACCESS} sdcr_state_t;

   sdcr_state_t state_q;
   sdcr_state_t state_d;
   logic        acc_phase;        // Access phase of a transfer
   logic        wr_acc;           // Write completing this cycle
   logic        cfg_load;         // A configuration word is loaded
   logic [3:0]  sel;              // Register select bits of the word
   logic        addr_ok;          // Mapped address

   // Access completes in the first access cycle (no wait states)
   assign acc_phase = psel_i && penable_i;
   assign wr_acc    = acc_phase && pwrite_i;
   assign sel       = pwdata_i[3:0];
   assign addr_ok   = (paddr_i == sdcr_pkg::ADDR_CFG_WORD)  || (paddr_i == sdcr_pkg::ADDR_LAST_WORD) ||
                      (paddr_i == sdcr_pkg::ADDR_STATUS)    || (paddr_i == sdcr_pkg::ADDR_INT_VAL)   ||
                      (paddr_i == sdcr_pkg::ADDR_MAIN_NUM)  || (paddr_i == sdcr_pkg::ADDR_AUX_VAL)   ||
                      (paddr_i == sdcr_pkg::ADDR_RF_DIV);
   // Only the load address takes writes, and only while pready stands
   assign cfg_load  = wr_acc && (state_q == SDCR_ACCESS) && (paddr_i == sdcr_pkg::ADDR_CFG_WORD);

   // Select decode helper
   function automatic logic hit(input logic [3:0] s, input logic [3:0] code);
      hit = cfg_load && (s == code);
   endfunction : hit

   logic ld0, ld1, ld2, ld3, ld4, ld5, ld6, ld7, ld8;
   assign ld0 = hit(sel, sdcr_pkg::SEL_INT_PRESC);
   assign ld1 = hit(sel, sdcr_pkg::SEL_MAIN_FRAC);
   assign ld2 = hit(sel, sdcr_pkg::SEL_AUX_DEN);
   assign ld3 = hit(sel, sdcr_pkg::SEL_AUX_NUM);
   assign ld4 = hit(sel, sdcr_pkg::SEL_R4);
   assign ld5 = hit(sel, sdcr_pkg::SEL_R5);
   assign ld6 = hit(sel, sdcr_pkg::SEL_RF_OUT);
   assign ld7 = hit(sel, sdcr_pkg::SEL_LOCK_DET);
   assign ld8 = hit(sel, sdcr_pkg::SEL_DITHER_PH);

   // Bus phase tracker: ACCESS marks the one cycle in which pready stands.
   // Zero wait states, so the tracker never stays in ACCESS.
   always_comb
   begin
      case (state_q)
         SDCR_IDLE:   state_d = (psel_i && !penable_i) ? SDCR_ACCESS : SDCR_IDLE;
         SDCR_ACCESS: state_d = SDCR_IDLE;
         default:     state_d = SDCR_IDLE;
      endcase
   end

   // Tracker state
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_q <= SDCR_IDLE;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Plain registers
   //
   // Register 0 and words 4, 5, 7 and 8 take effect on their load edge.
   // Register 0 is never buffered: its own write is the apply strobe.

   logic [31:0] int_word_q;       // Integer and prescaler word
   logic [31:0] r4_q;             // Word 4, holds the buffering enable
   logic [31:0] r5_q;             // Word 5, kept raw
   logic [31:0] lock_word_q;      // Lock detect word, kept raw
   logic [31:0] dither_word_q;    // Dither and phase word, kept raw
   logic [31:0] last_q;           // Last word loaded, whatever its select

   // Integer and prescaler word; this write also applies the shadows
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         int_word_q <= sdcr_pkg::WORD_RESET;
      end
      else if (ld0)
      begin
         int_word_q <= pwdata_i;
      end
   end

   // Word 4 steers the divider buffering from the edge after its load,
   // so a host must load it before the word 6 that it should govern
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         r4_q <= sdcr_pkg::WORD_RESET;
      end
      else if (ld4)
      begin
         r4_q <= pwdata_i;
      end
   end

   // Raw words for the analog side; their fields are not decoded here
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         r5_q          <= sdcr_pkg::WORD_RESET;
         lock_word_q   <= sdcr_pkg::WORD_RESET;
         dither_word_q <= sdcr_pkg::WORD_RESET;
      end
      else
      begin
         if (ld5) r5_q          <= pwdata_i;
         if (ld7) lock_word_q   <= pwdata_i;
         if (ld8) dither_word_q <= pwdata_i;
      end
   end

   // Last word follows every load, also select codes with no register
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         last_q <= sdcr_pkg::WORD_RESET;
      end
      else if (cfg_load)
      begin
         last_q <= pwdata_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Buffered words: 1, 2, 3 always; word 6 only in its divider bits, when enabled
   //
   // Each buffered word sits in a shadow holder that keeps the newest load
   // and moves it to the active side on a register 0 write, so the loop
   // never sees a fraction that is half old and half new.

   logic [31:0] main_act;         // Active main fraction word
   logic [31:0] aux_den_act;      // Active aux denominator word
   logic [31:0] aux_num_act;      // Active aux numerator word
   logic [31:0] rf_word_act;      // Active output and bleed word
   logic [2:0]  rfdiv_act;        // Active output divider select
   logic        p1;               // Main fraction waits for apply
   logic        p2;               // Aux denominator waits for apply
   logic        p3;               // Aux numerator waits for apply
   logic        p6;               // Never set: word 6 body is immediate
   logic        pdiv;             // Divider select waits for apply
   logic        div_buf;          // Divider select buffering enabled

   // Divider select buffering enable from word 4 bit 14
   assign div_buf = r4_q[sdcr_pkg::DBUF_EN_BIT];

   // Main fraction word, buffered until word 0 arrives
   sdcr_shadow #(.W(32)) u_sh1 (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .load_i    (ld1),
      .buffer_i  (1'b1),
      .apply_i   (ld0),
      .data_i    (pwdata_i),
      .active_o  (main_act),
      .pending_o (p1)
   );

   // Aux denominator word
   sdcr_shadow #(.W(32)) u_sh2 (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .load_i    (ld2),
      .buffer_i  (1'b1),
      .apply_i   (ld0),
      .data_i    (pwdata_i),
      .active_o  (aux_den_act),
      .pending_o (p2)
   );

   // Aux numerator word
   sdcr_shadow #(.W(32)) u_sh3 (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .load_i    (ld3),
      .buffer_i  (1'b1),
      .apply_i   (ld0),
      .data_i    (pwdata_i),
      .active_o  (aux_num_act),
      .pending_o (p3)
   );

   // Word 6 apart from the divider bits applies immediately
   sdcr_shadow #(.W(32)) u_sh6 (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .load_i    (ld6),
      .buffer_i  (1'b0),
      .apply_i   (1'b0),
      .data_i    (pwdata_i),
      .active_o  (rf_word_act),
      .pending_o (p6)
   );

   // Output divider select, buffered only when enabled
   sdcr_shadow #(.W(3)) u_shdiv (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .load_i    (ld6),
      .buffer_i  (div_buf),
      .apply_i   (ld0),
      .data_i    (pwdata_i[sdcr_pkg::RF_DIV_MSB:sdcr_pkg::RF_DIV_LSB]),
      .active_o  (rfdiv_act),
      .pending_o (pdiv)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Divider assembly
   //
   // The loop reads every divide field from one register, so prescaler,
   // whole value and fractions all change on the same edge.

   sdcr_pkg::sdcr_div_t div_d;    // Next divider set
   sdcr_pkg::sdcr_div_t div_q;    // Divider set seen by the loop

   // Fields gathered into one word so the loop sees a coherent set
   assign div_d.prescaler_select        = int_word_q[sdcr_pkg::PRESC_BIT];
   assign div_d.whole_value             = int_word_q[sdcr_pkg::INT_MSB:sdcr_pkg::INT_LSB];
   assign div_d.main_fraction_numerator = main_act[sdcr_pkg::MAIN_NUM_MSB:sdcr_pkg::MAIN_NUM_LSB];
   assign div_d.aux_denominator         = aux_den_act[sdcr_pkg::AUX_MSB:sdcr_pkg::AUX_LSB];
   assign div_d.aux_fraction_numerator  = aux_num_act[sdcr_pkg::AUX_MSB:sdcr_pkg::AUX_LSB];
   assign div_d.rf_divider_select       = rfdiv_act;
   // No range check: every numerator code is legal and limits are the host's job

   // Loop view register, one cycle behind the active fields
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         div_q <= '0;
      end
      else
      begin
         div_q <= div_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read mux

   logic [31:0] rd_d;
   logic [31:0] status_w;

   assign status_w = {26'h0, div_buf, pdiv, p3, p2, p1, p6};
   assign rd_d = (paddr_i == sdcr_pkg::ADDR_LAST_WORD) ? last_q :
                 (paddr_i == sdcr_pkg::ADDR_STATUS)    ? status_w :
                 (paddr_i == sdcr_pkg::ADDR_INT_VAL)   ? {15'h0, div_q.prescaler_select, div_q.whole_value} :
                 (paddr_i == sdcr_pkg::ADDR_MAIN_NUM)  ? {8'h0, div_q.main_fraction_numerator} :
                 (paddr_i == sdcr_pkg::ADDR_AUX_VAL)   ? {2'h0, div_q.aux_denominator, 2'h0,
                                                          div_q.aux_fraction_numerator} :
                 (paddr_i == sdcr_pkg::ADDR_RF_DIV)    ? {29'h0, div_q.rf_divider_select} :
                 32'h0000_0000;

   logic        answer_next;      // Access cycle follows this edge
   logic        ready_q;          // Transfer answer
   logic        err_q;            // Unmapped address answer
   logic [31:0] prdata_q;         // Read data, zero outside the answer

   // A setup cycle seen in idle moves the tracker to its access state
   assign answer_next = (state_d == SDCR_ACCESS);

   // pready and pslverr stand for the single access cycle
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ready_q <= 1'b0;
         err_q   <= 1'b0;
      end
      else
      begin
         ready_q <= answer_next;
         err_q   <= answer_next && !addr_ok;
      end
   end

   // Read data is captured at setup and zeroed otherwise, so a stale word
   // never shows on the bus outside its answer
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         prdata_q <= 32'h0000_0000;
      end
      else
      begin
         prdata_q <= (answer_next && !pwrite_i) ? rd_d : 32'h0000_0000;
      end
   end

   assign pready_o         = ready_q;
   assign pslverr_o        = err_q;
   assign prdata_o         = prdata_q;
   assign div_o            = div_q;
   assign r4_word_o        = r4_q;
   assign r5_word_o        = r5_q;
   assign rf_out_word_o    = rf_word_act;
   assign lock_det_word_o  = lock_word_q;
   assign dither_ph_word_o = dither_word_q;

endmodule : sdcr_regs

// ---- tb/sdcr_properties.sv ----
// Port checker for the divider configuration bank.
// Assumes zero-wait APB and div_o lagging the active fields by one cycle.
`timescale 1ns/1ns
module sdcr_properties (
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   input  wire logic                psel_i,
   input  wire logic                penable_i,
   input  wire logic                pwrite_i,
   input  wire logic [7:0]          paddr_i,
   input  wire logic [31:0]         pwdata_i,
   input  wire logic                pready_o,
   input  wire logic                pslverr_o,
   input  wire logic [31:0]         prdata_o,
   input  wire sdcr_pkg::sdcr_div_t div_o,
   input  wire logic [31:0]         r4_word_o,
   input  wire logic [31:0]         rf_out_word_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////
   wire         ld  = psel_i && penable_i && pwrite_i && pready_o && paddr_i == 8'h00; // Completed load
   wire  [3:0]  sel = pwdata_i[3:0];   // Register select code
   wire         ld0 = ld && sel == 4'h0; // Load that applies shadows
   logic [23:0] m1_q;                  // Last main numerator loaded
   logic [13:0] d2_q;                  // Last aux denominator loaded
   logic [13:0] n3_q;                  // Last aux numerator loaded
   // Mirrors of shadowed fields; cleared on reset just like the bank
   always_ff @(posedge clk_i)
      if (rst_i) m1_q <= 24'h000000;
      else if (ld && sel == 4'h1) m1_q <= pwdata_i[27:4];
   always_ff @(posedge clk_i)
      if (rst_i) d2_q <= 14'h0000;
      else if (ld && sel == 4'h2) d2_q <= pwdata_i[17:4];
   always_ff @(posedge clk_i)
      if (rst_i) n3_q <= 14'h0000;
      else if (ld && sel == 4'h3) n3_q <= pwdata_i[17:4];
   ////////////////////////////////////////////////////////////
   ready_after_setup_a: assert property (psel_i && !penable_i |=> pready_o)
      else $error("pready missing in access cycle");
   ready_single_a: assert property (pready_o |=> !pready_o)
      else $error("pready held too long");
   whole_apply_a: assert property (ld0 |-> ##2 div_o.whole_value == $past(pwdata_i[19:4], 2))
      else $error("whole value not applied");
   presc_apply_a: assert property (ld0 |-> ##2 div_o.prescaler_select == $past(pwdata_i[20], 2))
      else $error("prescaler not applied");
   main_apply_a: assert property (ld0 |-> ##2 div_o.main_fraction_numerator == m1_q)
      else $error("main numerator not applied");
   aux_apply_a: assert property (ld0 |-> ##2 {div_o.aux_denominator, div_o.aux_fraction_numerator} == {d2_q, n3_q})
      else $error("aux fields not applied");
   main_held_a: assert property (ld && sel == 4'h1 |-> ##2 $stable(div_o.main_fraction_numerator))
      else $error("main numerator bypassed shadow");
   word4_store_a: assert property (ld && sel == 4'h4 |=> r4_word_o == $past(pwdata_i))
      else $error("word 4 not stored");
   rf_direct_a: assert property (ld && sel == 4'h6 && !r4_word_o[14] |=> rf_out_word_o == $past(pwdata_i))
      else $error("word 6 not taken at once");
   unmapped_err_a: assert property (psel_i && !penable_i && paddr_i > 8'h18 |=> pslverr_o)
      else $error("no error on unmapped address");
   rdata_idle_a: assert property (!pready_o |-> prdata_o == 32'h00000000)
      else $error("read data outside answer");
endmodule : sdcr_properties

// ---- tb/sdcr_host.sv ----
// Host model: APB master loading configuration words into the bank.
// Assumes the bank answers with pready; the bench bounds every wait.
`timescale 1ns/1ns
module sdcr_host (
   input  wire logic        clk_i,
   input  wire logic        pready_i,
   input  wire logic        pslverr_i,
   input  wire logic [31:0] prdata_i,
   output logic             psel_o    = 1'b0,
   output logic             penable_o = 1'b0,
   output logic             pwrite_o  = 1'b0,
   output logic [7:0]       paddr_o   = 8'h00,
   output logic [31:0]      pwdata_o  = 32'h00000000
);
   ////////////////////////////////////////////////////////////
   // Words handed in keep whole values and aux fractions legal
   // One whole 32-bit transfer, held until pready is seen high
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
      @(posedge clk_i);
      psel_o   <= 1'b1;
      pwrite_o <= w;
      paddr_o  <= a;
      pwdata_o <= d;
      @(posedge clk_i);
      penable_o <= 1'b1;
      do @(posedge clk_i); while (pready_i !== 1'b1);
      rd = prdata_i;
      er = pslverr_i;
      psel_o    <= 1'b0;
      penable_o <= 1'b0;
      pwdata_o  <= ~d;   // Released bus must not keep showing the word
   endtask : xfer
endmodule : sdcr_host

// ---- tb/tb_synth_divider_config_registers.sv ----
// Self-checking bench for the divider configuration bank.
// Assumes the host model drives APB; the checker is bound at the foot.
`timescale 1ns/1ns
module tb_synth_divider_config_registers;
   logic                clk_i = 1'b0;
   logic                rst_i = 1'b1;
   logic                psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
   logic [7:0]          paddr_i;
   logic [31:0]         pwdata_i, prdata_o, rd, r4_o, r5_o, rf_o, ld_o, dp_o;
   sdcr_pkg::sdcr_div_t div_o;
   logic                er;
   logic [3:0]          sels [3] = '{4'h5, 4'h7, 4'h8};  // Plain stored words
   int                  err_count = 0;
   int                  n_checks  = 0;
   int                  cycles    = 0;
   ////////////////////////////////////////////////////////////
   sdcr_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .prdata_o(prdata_o), .div_o(div_o), .r4_word_o(r4_o), .r5_word_o(r5_o),
      .rf_out_word_o(rf_o), .lock_det_word_o(ld_o), .dither_ph_word_o(dp_o));
   sdcr_host host_u (.clk_i(clk_i), .pready_i(pready_o), .pslverr_i(pslverr_o), .prdata_i(prdata_o),
      .psel_o(psel_i), .penable_o(penable_i), .pwrite_o(pwrite_i), .paddr_o(paddr_i), .pwdata_o(pwdata_i));
   // 125 MHz clock
   initial forever #4 clk_i = ~clk_i;
   // Hang guard: the run needs about a hundred cycles
   always @(posedge clk_i)
   begin
      cycles <= cycles + 1;
      if (cycles == 2000)
      begin
         err_count++;
         final_report();
      end
   end
   ////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      n_checks++;
      if (got !== ex)
      begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", nm, ex, got);
      end
   endtask : chk
   // Load one word, then wait out the loop view lag
   task automatic wr(input logic [31:0] d);
      host_u.xfer(1'b1, 8'h00, d, rd, er);
      repeat (2) @(posedge clk_i);
      #1;
   endtask : wr
   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] ex);
      host_u.xfer(1'b0, a, 32'h00000000, rd, er);
      chk(nm, ex, rd);
   endtask : rd_chk
   task automatic final_report();
      if (err_count == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : final_report
   ////////////////////////////////////////////////////////////
   // Main sequence: shadows, apply, divider buffering, plain words, errors
   initial
   begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      #1;
      chk("whole after reset", 32'h00000000, 32'(div_o.whole_value));
      wr({14'h0000, 14'd100, 4'h2});
      wr({14'h0000, 14'd7, 4'h3});
      wr({4'h0, 24'hFFFFFF, 4'h1});
      chk("main held", 32'h00000000, 32'(div_o.main_fraction_numerator));
      rd_chk("pending", 8'h08, 32'h0000000E);
      wr({11'h000, 1'b1, 16'd75, 4'h0});
      chk("whole", 32'd75, 32'(div_o.whole_value));
      chk("prescaler", 32'd1, 32'(div_o.prescaler_select));
      chk("main", 32'h00FFFFFF, 32'(div_o.main_fraction_numerator));
      chk("aux", {4'h0, 14'd100, 14'd7}, {4'h0, div_o.aux_denominator, div_o.aux_fraction_numerator});
      rd_chk("int view", 8'h0C, 32'h0001004B);
      rd_chk("main view", 8'h10, 32'h00FFFFFF);
      rd_chk("aux view", 8'h14, 32'h00640007);
      wr(32'h00004004);
      wr(32'h00A00006);
      chk("rf held", 32'd0, 32'(div_o.rf_divider_select));
      wr({11'h000, 1'b0, 16'd23, 4'h0});
      chk("rf applied", 32'd5, 32'(div_o.rf_divider_select));
      wr(32'h00000004);
      wr(32'h00600006);
      chk("rf direct", 32'd3, 32'(div_o.rf_divider_select));
      rd_chk("rf view", 8'h18, 32'h00000003);
      for (int i = 0; i < 3; i++)
      begin
         wr({28'h5A3C96F, sels[i]});
         chk("word", {28'h5A3C96F, sels[i]}, (i == 0) ? r5_o : (i == 1) ? ld_o : dp_o);
      end
      wr(32'hFFFFFFF9);
      chk("whole kept", 32'd23, 32'(div_o.whole_value));
      host_u.xfer(1'b1, 8'h04, 32'h12345674, rd, er);
      chk("mapped write error", 32'd0, 32'(er));
      rd_chk("last word", 8'h04, 32'hFFFFFFF9);
      host_u.xfer(1'b0, 8'h40, 32'h00000000, rd, er);
      chk("slave error", 32'd1, 32'(er));
      final_report();
   end
endmodule : tb_synth_divider_config_registers

bind sdcr_regs sdcr_properties chk_u (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .prdata_o(prdata_o), .div_o(div_o), .r4_word_o(r4_word_o), .rf_out_word_o(rf_out_word_o));
